/* hdl/irq_ctrl_pkg.sv */
/*
 * package for the priority interrupt unit: register offsets, write masks,
 * reset values, field layout helpers and the request bundle to the core.
 * assumes a 16-bit register port with word offsets and one 100 MHz clock.
 */
package irq_ctrl_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC        = 46;
    localparam int NUM_FIXED      = 2;
    localparam int NUM_FIELDS     = 30;
    localparam int ADDR_W         = 5;
    localparam int DATA_W         = 16;
    localparam int VEC_ADDR_W     = 21;

    // ------------------------------------------------------------
    // register offsets (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_PRIO_0     = 5'h00;
    localparam logic [4:0] OFS_PRIO_4     = 5'h04;
    localparam logic [4:0] OFS_VEC_BASE   = 5'h05;
    localparam logic [4:0] OFS_FMATCH_0   = 5'h06;
    localparam logic [4:0] OFS_FLO_0      = 5'h07;
    localparam logic [4:0] OFS_FHI_0      = 5'h08;
    localparam logic [4:0] OFS_FMATCH_1   = 5'h09;
    localparam logic [4:0] OFS_FLO_1      = 5'h0A;
    localparam logic [4:0] OFS_FHI_1      = 5'h0B;
    localparam logic [4:0] OFS_PEND_0     = 5'h0C;
    localparam logic [4:0] OFS_PEND_1     = 5'h0D;
    localparam logic [4:0] OFS_PEND_2     = 5'h0E;
    localparam logic [4:0] OFS_CONTROL    = 5'h12;
    localparam logic [4:0] OFS_EVT_STATUS = 5'h13;
    localparam logic [4:0] OFS_EVT_CLEAR  = 5'h14;
    localparam logic [4:0] OFS_EVT_ENABLE = 5'h15;

    // ------------------------------------------------------------
    // writable bits and reset values
    // ------------------------------------------------------------
    localparam logic [79:0] PRIO_WMASK    = {16'h00FF, 16'hFFF0, 16'hF3FF, 16'hFCFF, 16'hC3FF};
    localparam logic [15:0] PRIO_RST      = 16'h0000;
    localparam logic [15:0] VEC_BASE_MASK = 16'h3FFF;
    localparam logic [15:0] FMATCH_MASK   = 16'h003F;
    localparam logic [15:0] FHI_MASK      = 16'h001F;
    localparam logic [15:0] REG_RST       = 16'h0000;
    localparam int          CTRL_DIS_BIT  = 5;
    localparam logic [2:0]  CTRL_ONES     = 3'h7;
    localparam logic [15:0] PEND0_FILL    = 16'h0001;
    localparam logic [15:0] PEND2_FILL    = 16'hE000;
    localparam int          EOC_FIELD_TOP = 10;
    localparam logic [1:0]  FIXED_LEVEL   = 2'h3;
    localparam logic [1:0]  FAST_LEVEL    = 2'h2;
    localparam int          NUM_EVT       = 3;
    localparam logic [2:0]  EVT_RST       = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  valid;
        logic                  fast;
        logic [1:0]            level;
        logic [VEC_ADDR_W-1:0] vec_addr;
    } core_req_t;

    // bit position of the k-th implemented priority field in the joined 80-bit image
    function automatic int field_pos(input int k);
        int n;
        int pos;
        n   = 0;
        pos = 0;
        for (int p = 0; p < 40; p++) begin
            if (PRIO_WMASK[2*p]) begin
                if (n == k) begin
                    pos = 2 * p;
                end
                n++;
            end
        end
        return pos;
    endfunction

endpackage

/* hdl/priority_interrupt_unit.sv */
/*
 * priority interrupt unit: priority registers, per-level encoding, nesting
 * mask, normal and fast vector formation, wake request and event interrupt.
 * assumes sources, core mask and low-power flag come from logic on core_clk.
 */
`timescale 1ns/1ps

// Summary of operation
// - 46 sources, 30 of them with three software levels
// - lowest source number wins within level
// - pending request raises wake in low power
// - only pre-sleep enabled sources may wake
// - normal vector is base joined with number
// - core mask bits permit level and above
// - fast when match and level two
// - fast vector from matching address pair
// - nineteen registers at base plus offset
// - five priority registers, unused bits zero
// - vector base top two bits zero
// - fast match holds vector number only
// - fast address split low and high
// - pending flags 2..45, empty bits one
// - field 00 disables, others raise level
// - reserved priority bits read zero
module priority_interrupt_unit
    import irq_ctrl_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic [irq_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [irq_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [irq_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] irq_src,
    input  wire logic [1:0]                 core_mask,
    input  wire logic                       low_power,
    output irq_ctrl_pkg::core_req_t         core_req,
    output logic                            wake_req,
    output logic                            irq_out
);
    import irq_ctrl_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [79:0]            prio_r;
    logic [15:0]            vec_base_r;
    logic [15:0]            fmatch_r [2];
    logic [15:0]            flo_r    [2];
    logic [15:0]            fhi_r    [2];
    logic                   gdis_r;
    logic [NUM_EVT-1:0]     evt_status_r;
    logic [NUM_EVT-1:0]     evt_enable_r;
    logic [NUM_SRC-1:0]     en_snap_r;
    logic                   lp_d_r;
    logic [DATA_W-1:0]      rdata_r;
    core_req_t              req_r;
    logic                   wake_r;
    logic                   irq_r;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic in_prio   = (reg_addr <= OFS_PRIO_4);
    wire logic hit_vb    = (reg_addr == OFS_VEC_BASE);
    wire logic hit_fm0   = (reg_addr == OFS_FMATCH_0);
    wire logic hit_fl0   = (reg_addr == OFS_FLO_0);
    wire logic hit_fh0   = (reg_addr == OFS_FHI_0);
    wire logic hit_fm1   = (reg_addr == OFS_FMATCH_1);
    wire logic hit_fl1   = (reg_addr == OFS_FLO_1);
    wire logic hit_fh1   = (reg_addr == OFS_FHI_1);
    wire logic hit_ctl   = (reg_addr == OFS_CONTROL);
    wire logic hit_est   = (reg_addr == OFS_EVT_STATUS);
    wire logic hit_eclr  = (reg_addr == OFS_EVT_CLEAR);
    wire logic hit_een   = (reg_addr == OFS_EVT_ENABLE);
    wire logic [2:0] prio_idx = reg_addr[2:0];

    // ------------------------------------------------------------
    // per-source enable and level
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] src_en;
    logic [1:0]         src_lvl [NUM_SRC];

    genvar gs;
    generate
        for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
            if (gs < NUM_FIXED) begin : g_fixed
                assign src_en[gs]  = 1'b1;
                assign src_lvl[gs] = FIXED_LEVEL;
            end else if (gs < NUM_FIXED + NUM_FIELDS) begin : g_prog
                localparam int POS  = field_pos(gs - NUM_FIXED);
                localparam int BASE = (POS < EOC_FIELD_TOP) ? 1 : 0;
                wire logic [1:0] fld = prio_r[POS +: 2];
                assign src_en[gs]  = (fld != 2'h0);
                assign src_lvl[gs] = fld - 2'h1 + 2'(BASE);
            end else begin : g_none
                assign src_en[gs]  = 1'b0;
                assign src_lvl[gs] = 2'h0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // level encoding and arbitration
    // ------------------------------------------------------------
    function automatic logic [5:0] lowest_set(input logic [NUM_SRC-1:0] v);
        logic [5:0] idx;
        idx = 6'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    logic [NUM_SRC-1:0] lvl_req [4];
    logic [3:0]         lvl_any;
    logic [5:0]         lvl_win [4];

    genvar gl;
    generate
        for (gl = 0; gl < 4; gl++) begin : g_lvl
            for (genvar k = 0; k < NUM_SRC; k++) begin : g_bit
                assign lvl_req[gl][k] = irq_src[k] & src_en[k] & (src_lvl[k] == 2'(gl));
            end
            assign lvl_any[gl] = |lvl_req[gl];
            assign lvl_win[gl] = lowest_set(lvl_req[gl]);
        end
    endgenerate

    // highest requesting level first; the mask then decides if it may go
    wire logic [1:0] top_lvl = lvl_any[3] ? 2'h3 : lvl_any[2] ? 2'h2 : lvl_any[1] ? 2'h1 : 2'h0;
    wire logic [5:0] top_src = lvl_win[top_lvl];
    wire logic permitted     = (|lvl_any) && (top_lvl >= core_mask);
    wire logic take          = permitted && !gdis_r;

    // ------------------------------------------------------------
    // vector formation
    // ------------------------------------------------------------
    wire logic match0 = (fmatch_r[0][5:0] == top_src);
    wire logic match1 = (fmatch_r[1][5:0] == top_src);
    wire logic is_fast = (match0 || match1) && (top_lvl == FAST_LEVEL);
    wire logic [VEC_ADDR_W-1:0] norm_addr = {vec_base_r[13:0], top_src, 1'b0};
    wire logic [VEC_ADDR_W-1:0] fast_addr = match0 ? {fhi_r[0][4:0], flo_r[0]}
                                                   : {fhi_r[1][4:0], flo_r[1]};

    core_req_t req_nxt;
    assign req_nxt.valid    = take;
    assign req_nxt.fast     = take && is_fast;
    assign req_nxt.level    = take ? top_lvl : 2'h0;
    assign req_nxt.vec_addr = !take ? '0 : is_fast ? fast_addr : norm_addr;

    // ------------------------------------------------------------
    // wake request
    // ------------------------------------------------------------
    wire logic lp_enter = low_power && !lp_d_r;
    // sources enabled after sleep began must not wake, so a snapshot is used
    wire logic wake_nxt = low_power && |(irq_src & en_snap_r);

    // ------------------------------------------------------------
    // pending view and read mux
    // ------------------------------------------------------------
    wire logic [15:0] pend0 = {irq_src[16:2], 1'b0} | PEND0_FILL;
    wire logic [15:0] pend1 = irq_src[32:17];
    wire logic [15:0] pend2 = {3'h0, irq_src[45:33]} | PEND2_FILL;
    wire logic [15:0] ctrl_view = {req_r.valid, req_r.level, req_r.vec_addr[7:1],
                                   gdis_r, CTRL_ONES, 2'h0};
    wire logic [15:0] prio_view = prio_r[16*prio_idx +: 16];

    wire logic [15:0] rd_mux =
        in_prio            ? prio_view :
        hit_vb             ? (vec_base_r & VEC_BASE_MASK) :
        hit_fm0            ? (fmatch_r[0] & FMATCH_MASK) :
        hit_fl0            ? flo_r[0] :
        hit_fh0            ? (fhi_r[0] & FHI_MASK) :
        hit_fm1            ? (fmatch_r[1] & FMATCH_MASK) :
        hit_fl1            ? flo_r[1] :
        hit_fh1            ? (fhi_r[1] & FHI_MASK) :
        (reg_addr == OFS_PEND_0) ? pend0 :
        (reg_addr == OFS_PEND_1) ? pend1 :
        (reg_addr == OFS_PEND_2) ? pend2 :
        hit_ctl            ? ctrl_view :
        hit_est            ? {13'h0, evt_status_r} :
        hit_een            ? {13'h0, evt_enable_r} : 16'h0000;

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    wire logic [NUM_EVT-1:0] evt_set = {req_nxt.fast && !req_r.fast,
                                        wake_nxt && !wake_r,
                                        take && !req_r.valid};
    wire logic [NUM_EVT-1:0] evt_clr = (reg_wr && hit_eclr) ? reg_wdata[NUM_EVT-1:0] : '0;
    // a set in the same cycle as its clear wins so no event is lost
    wire logic [NUM_EVT-1:0] evt_status_nxt = evt_set | (evt_status_r & ~evt_clr);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prio_r <= {5{PRIO_RST}};
        end else if (reg_wr && in_prio) begin
            prio_r[16*prio_idx +: 16] <= reg_wdata & PRIO_WMASK[16*prio_idx +: 16];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vec_base_r <= REG_RST;
            fmatch_r   <= '{REG_RST, REG_RST};
            flo_r      <= '{REG_RST, REG_RST};
            fhi_r      <= '{REG_RST, REG_RST};
            gdis_r     <= 1'b0;
        end else if (reg_wr) begin
            if (hit_vb) begin
                vec_base_r <= reg_wdata & VEC_BASE_MASK;
            end
            if (hit_fm0) begin
                fmatch_r[0] <= reg_wdata & FMATCH_MASK;
            end
            if (hit_fm1) begin
                fmatch_r[1] <= reg_wdata & FMATCH_MASK;
            end
            if (hit_fl0) begin
                flo_r[0] <= reg_wdata;
            end
            if (hit_fl1) begin
                flo_r[1] <= reg_wdata;
            end
            if (hit_fh0) begin
                fhi_r[0] <= reg_wdata & FHI_MASK;
            end
            if (hit_fh1) begin
                fhi_r[1] <= reg_wdata & FHI_MASK;
            end
            if (hit_ctl) begin
                gdis_r <= reg_wdata[CTRL_DIS_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            evt_status_r <= EVT_RST;
            evt_enable_r <= EVT_RST;
        end else begin
            evt_status_r <= evt_status_nxt;
            if (reg_wr && hit_een) begin
                evt_enable_r <= reg_wdata[NUM_EVT-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and sleep snapshot
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r   <= 16'h0000;
            req_r     <= '0;
            wake_r    <= 1'b0;
            irq_r     <= 1'b0;
            lp_d_r    <= 1'b0;
            en_snap_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 16'h0000;
            req_r   <= req_nxt;
            wake_r  <= wake_nxt;
            irq_r   <= |(evt_status_nxt & evt_enable_r);
            lp_d_r  <= low_power;
            if (lp_enter) begin
                en_snap_r <= src_en;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign core_req  = req_r;
    assign wake_req  = wake_r;
    assign irq_out   = irq_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_mask_gates_level: assert property (core_req.valid |-> core_req.level >= $past(core_mask))
        else $error("request at masked level");
    a_fast_at_two: assert property (core_req.fast |-> core_req.valid && core_req.level == 2'h2)
        else $error("fast request not at level two");
    a_normal_vector: assert property (core_req.valid && !core_req.fast
                                      |-> core_req.vec_addr[20:7] == $past(vec_base_r[13:0]))
        else $error("normal vector not built from base");
    a_wake_needs_sleep: assert property (wake_req |-> $past(low_power) && $past(|irq_src))
        else $error("wake without sleep and request");
    a_late_enable_no_wake: assert property (low_power && irq_src != '0 && (irq_src & en_snap_r) == '0
                                            |=> !wake_req)
        else $error("wake by source enabled during sleep");
    a_read_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_prio4_upper_zero: assert property (reg_rd && reg_addr == OFS_PRIO_4 |=> reg_rdata[15:8] == 8'h00)
        else $error("unused priority bits not zero");
    a_pend_fill_ones: assert property (reg_rd && reg_addr == OFS_PEND_2 |=> reg_rdata[15:13] == 3'h7)
        else $error("empty pending bits not one");
    a_base_top_zero: assert property (reg_rd && reg_addr == OFS_VEC_BASE |=> reg_rdata[15:14] == 2'h0)
        else $error("vector base top bits not zero");
    a_lowest_wins: assert property (irq_src[0] && !gdis_r |=> core_req.valid && core_req.vec_addr[6:1] == 6'h00)
        else $error("source zero did not win");
    a_disabled_quiet: assert property (prio_r == '0 && irq_src[45:2] != '0 && irq_src[1:0] == 2'h0
                                       |=> !core_req.valid)
        else $error("disabled source reached core");
    a_irq_follows: assert property (irq_out |-> $past(|(evt_status_nxt & evt_enable_r)))
        else $error("interrupt without enabled event");

    c_fast_taken: cover property (core_req.fast);
    c_wake_seen: cover property (low_power ##1 wake_req);
    c_normal_then_read: cover property (core_req.valid && !core_req.fast ##1 reg_rd);
    c_event_irq: cover property (irq_out);

endmodule

/* test/core_side_model.sv */
/*
 * model of the core and the clock integration unit beside the interrupt unit.
 * assumes one core_clk; the bench steers the mask and sleep entry by command.
 */
`timescale 1ns/1ps

module core_side_model
    import irq_ctrl_pkg::*;
(
    input  wire logic                                core_clk,
    input  wire logic                                sys_rst,
    input  wire irq_ctrl_pkg::core_req_t             core_req,
    input  wire logic                                wake_req,
    input  wire logic [1:0]                          mask_cmd,
    input  wire logic                                sleep_cmd,
    output logic      [1:0]                          core_mask,
    output logic                                     low_power,
    output logic      [irq_ctrl_pkg::VEC_ADDR_W-1:0] fetch_addr
);
    logic [1:0] mask_r;
    logic       sleep_r;

    // ------------------------------------------------------------
    // status word mask, sleep state and vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mask_r     <= 2'h0;
            sleep_r    <= 1'b0;
            fetch_addr <= '0;
        end else begin
            mask_r <= mask_cmd;
            // clocks restart one cycle after a wake is signalled, and wake wins over sleep_cmd; sleep entry also waits a cycle
            sleep_r <= wake_req ? 1'b0 : (sleep_cmd | sleep_r);
            if (core_req.valid) begin
                fetch_addr <= core_req.vec_addr;
            end
        end
    end

    assign core_mask = mask_r;
    assign low_power = sleep_r;
endmodule

/* test/priority_interrupt_controller_tb.sv */
/*
 * self-checking bench for the priority interrupt unit over its register port.
 * assumes the core side model above and the package constants of the design.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

module priority_interrupt_controller_tb;
    import irq_ctrl_pkg::*;
    logic                  core_clk;
    logic                  sys_rst;
    logic [ADDR_W-1:0]     reg_addr;
    logic [DATA_W-1:0]     reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [DATA_W-1:0]     reg_rdata;
    logic [NUM_SRC-1:0]    irq_src;
    logic [1:0]            core_mask;
    logic [1:0]            mask_cmd;
    logic                  low_power;
    logic                  sleep_cmd;
    core_req_t             core_req;
    logic                  wake_req;
    logic                  irq_out;
    logic [VEC_ADDR_W-1:0] fetch_addr;
    int                    error_cnt;
    int                    check_count;
    int                    cycles;

    priority_interrupt_unit DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_src(irq_src), .core_mask(core_mask), .low_power(low_power), .core_req(core_req),
        .wake_req(wake_req), .irq_out(irq_out));
    core_side_model core_model (.core_clk(core_clk), .sys_rst(sys_rst), .core_req(core_req),
        .wake_req(wake_req), .mask_cmd(mask_cmd), .sleep_cmd(sleep_cmd), .core_mask(core_mask),
        .low_power(low_power), .fetch_addr(fetch_addr));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    // a hung wait would otherwise stall the run forever
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end

    function automatic logic [15:0] wr_mask(input logic [4:0] a);
        if (a <= OFS_PRIO_4) return PRIO_WMASK[16*a +: 16];
        case (a)
            OFS_VEC_BASE: return VEC_BASE_MASK;
            OFS_FMATCH_0, OFS_FMATCH_1: return FMATCH_MASK;
            OFS_FLO_0, OFS_FLO_1: return 16'hFFFF;
            OFS_FHI_0, OFS_FHI_1: return FHI_MASK;
            OFS_EVT_ENABLE: return 16'h0007;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] rst_val(input logic [4:0] a);
        return (a == OFS_PEND_0) ? PEND0_FILL : ((a == OFS_PEND_2) ? PEND2_FILL : 16'h0000);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // covers the mask register stage in the core model as well
    task automatic src(input logic [NUM_SRC-1:0] v);
        @(posedge core_clk);
        irq_src <= v;
        tick(3);
    endtask

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        core_clk    = 1'b0;
        sys_rst     = 1'b1;
        reg_addr    = '0;
        reg_wdata   = '0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        irq_src     = '0;
        mask_cmd    = 2'h0;
        sleep_cmd   = 1'b0;
        error_cnt   = 0;
        check_count = 0;
        cycles      = 0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 22; a++) begin
            if (a != OFS_CONTROL) rdchk(5'(a), rst_val(5'(a)));
        end
        for (int a = 0; a < 22; a++) begin
            if (a == OFS_CONTROL) continue;
            wr(5'(a), 16'hFFFF);
            rdchk(5'(a), wr_mask(5'(a)) | rst_val(5'(a)));
            wr(5'(a), 16'h0000);
        end
        src(46'h1 << 2 | 46'h1 << 45);
        rdchk(OFS_PEND_0, 16'h0003);
        rdchk(OFS_PEND_2, 16'hF000);
        $display("test registers done");
        wr(OFS_VEC_BASE, 16'h0123);
        src(46'h3);
        `CHK(core_req.vec_addr, {14'h0123, 6'd0, 1'b0})
        `CHK(core_req.level, FIXED_LEVEL)
        src(46'h2);
        `CHK(core_req.vec_addr, {14'h0123, 6'd1, 1'b0})
        for (int v = 0; v < 4; v++) begin
            for (int m = 0; m < 4; m++) begin
                wr(OFS_PRIO_0, 16'(v) << 14);
                @(posedge core_clk);
                mask_cmd <= 2'(m);
                src(46'h1 << 7);
                `CHK(core_req.valid, 1'(v != 0 && v - 1 >= m))
                if (v != 0 && v - 1 >= m) `CHK(core_req.level, 2'(v - 1))
            end
        end
        @(posedge core_clk);
        mask_cmd <= 2'h0;
        $display("test nesting done");
        wr(OFS_FMATCH_1, 16'h0007);
        wr(OFS_FLO_1, 16'hBEEF);
        wr(OFS_FHI_1, 16'h0015);
        wr(OFS_PRIO_0, 16'hC000);
        tick(3);
        `CHK(core_req.fast, 1'b1)
        `CHK(core_req.vec_addr, {5'h15, 16'hBEEF})
        `CHK(fetch_addr, {5'h15, 16'hBEEF})
        wr(OFS_FMATCH_0, 16'h0007);
        wr(OFS_FLO_0, 16'h1234);
        wr(OFS_FHI_0, 16'h000A);
        tick(3);
        `CHK(core_req.vec_addr, {5'h0A, 16'h1234})
        wr(OFS_PRIO_0, 16'h8000);
        tick(3);
        `CHK(core_req.fast, 1'b0)
        `CHK(core_req.vec_addr, {14'h0123, 6'd7, 1'b0})
        wr(OFS_CONTROL, 16'h0020);
        tick(3);
        `CHK(core_req.valid, 1'b0)
        rdchk(OFS_CONTROL, 16'h003C);
        wr(OFS_CONTROL, 16'h0000);
        src('0);
        $display("test vectors done");
        wr(OFS_PRIO_0, 16'h4000);
        @(posedge core_clk);
        sleep_cmd <= 1'b1;
        @(posedge core_clk);
        sleep_cmd <= 1'b0;
        tick(2);
        wr(OFS_PRIO_0, 16'h400C);
        src(46'h1 << 3);
        `CHK(wake_req, 1'b0)
        @(posedge core_clk);
        irq_src <= 46'h1 << 3 | 46'h1 << 7;
        tick(1);
        `CHK(wake_req, 1'b1)
        src('0);
        $display("test wake done");
        wr(OFS_EVT_CLEAR, 16'h0007);
        wr(OFS_EVT_ENABLE, 16'h0001);
        src(46'h1);
        `CHK(irq_out, 1'b1)
        rdchk(OFS_EVT_STATUS, 16'h0001);
        wr(OFS_EVT_CLEAR, 16'h0001);
        tick(1);
        `CHK(irq_out, 1'b0)
        wr(OFS_EVT_ENABLE, 16'h0000);
        src('0);
        src(46'h1);
        `CHK(irq_out, 1'b0)
        wr(OFS_EVT_ENABLE, 16'h0001);
        tick(1);
        `CHK(irq_out, 1'b1)
        $display("test events done");
        print_verdict();
    end
endmodule
